//--- ddr_defs.vh
// constants for the door driver control and status register block
`ifndef DDR_DEFS_VH
`define DDR_DEFS_VH
`define DDR_SYS_CLK_HZ 25000000
`define DDR_FRAME_BITS 5'd24
`define DDR_CNT_MAX 5'h1f
`define DDR_OP_WRITE 2'b00
`define DDR_OP_READ 2'b01
`define DDR_OP_MSB 23
`define DDR_ADDR_MSB 21
`define DDR_ADDR_LSB 16
`define DDR_DATA_MSB 15
`define DDR_DATA_LSB 1
`define DDR_DATA_W 15
`define DDR_NUM_CTRL 9
`define DDR_CTRL_LAST 6'h08
`define DDR_IMMED_FIRST 6'h06
`define DDR_ADDR_FAIL 6'h10
`define DDR_ADDR_SUPPLY 6'h11
`define DDR_ADDR_THERM 6'h12
`define DDR_ADDR_CF1 6'h13
`define DDR_ADDR_CF2 6'h14
`define DDR_ADDR_CF3 6'h15
`define DDR_ADDR_CF4 6'h16
`define DDR_ADDR_CF5 6'h17
`define DDR_ADDR_CF6 6'h18
`define DDR_CTRL_RESET 15'h0000
`define DDR_CR0_FREQ_LSB 12
`define DDR_CR0_HS_LSB 6
`define DDR_CR0_LS_LSB 0
`define DDR_CF_W 10
`define DDR_PWM_BASE_HZ 10240
`define DDR_PWM_STEP_HZ 2048
`define DDR_PWM_PER_W 12
`endif

//--- ddr_regs.v
// serial-link register bank: control shadows, status readback, pwm rate and driver polarity
`timescale 1ns/10ps
`default_nettype none
`include "ddr_defs.vh"
// Notes on behaviour
// RULE1: status addresses 0x10 to 0x18 are read only; writes there change nothing.
// RULE2: writes to 00H-05H during timed actuation are held, applied after it ends.
// RULE3: writes to 06H-08H apply as soon as chip select returns high.
// RULE4: every writable register accepts writes at any time, even during actuation.
// RULE5: host keeps override and polarity bits unchanged during timed actuation.
// RULE6: host keeps override bits unchanged while actuate-all bit is set.
// RULE7: each frame carries address, data and parity; control writes configure outputs.
// RULE8: 00H holds pwm select 15:13, high sides 12:7, low sides 6:1.
// RULE9: integrated driver control data bits are zero after reset.
// RULE10: 00H readable and writable anytime and kept after actuation ends.
// RULE11: per output, only one side set drives it; none or both gives tristate.
// RULE12: pwm rate is 10.240 kHz plus 2.048 kHz per select code step.
// RULE13: the selected pwm rate is shared by all six integrated drivers.
// RULE14: global faults plus per-side output faults are reported.
// RULE15: every response carries the global status byte in bits 23 to 16.
// RULE16: status layouts of 0x10 to 0x18 as given, with 10-bit current feedback.
// RULE17: command word is two opcode bits, six address bits, data and parity.
// RULE18: odd parity checked on incoming frames and generated on outgoing ones.
// RULE19: a frame without exactly 24 clocks flags serial error, data dropped.
// RULE20: reserved status bits read zero and are covered by response parity.
// RULE21: a write with bad parity changes nothing and sets the write fail flag.
module ddr_regs (
    input wire sys_clk_in,
    input wire resetn_in,
    input wire sclk_in,
    input wire chip_select_n_in,
    input wire mosi_in,
    output reg miso_out,
    output wire miso_oe_out,
    input wire actuation_busy_in,
    input wire [11:0] output_fault_code_in,
    input wire logic_supply_undervoltage_in,
    input wire state_bit_high_in,
    input wire state_bit_low_in,
    input wire [7:0] drain_source_flag_in,
    input wire [3:0] external_fault_code_in,
    input wire pump_low_flag_in,
    input wire battery_low_inhibit_flag_in,
    input wire battery_overvoltage_flag_in,
    input wire [5:0] thermal_shutdown_flag_in,
    input wire [5:0] thermal_warning_flag_in,
    input wire aux_rail_undervoltage_in,
    input wire [59:0] current_feedback_value_in,
    output reg [134:0] ctrl_active_out,
    output reg [5:0] high_side_on_out,
    output reg [5:0] low_side_on_out,
    output reg pwm_tick_out
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and edge finding

reg sclk_m_reg;
reg sclk_s_reg;
reg sclk_d_reg;
reg cs_m_reg;
reg cs_s_reg;
reg cs_d_reg;
reg mosi_m_reg;
reg mosi_s_reg;

always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        sclk_m_reg <= 1'b0;
        sclk_s_reg <= 1'b0;
        sclk_d_reg <= 1'b0;
        cs_m_reg <= 1'b1;
        cs_s_reg <= 1'b1;
        cs_d_reg <= 1'b1;
        mosi_m_reg <= 1'b0;
        mosi_s_reg <= 1'b0;
    end else begin
        sclk_m_reg <= sclk_in;
        sclk_s_reg <= sclk_m_reg;
        sclk_d_reg <= sclk_s_reg;
        cs_m_reg <= chip_select_n_in;
        cs_s_reg <= cs_m_reg;
        cs_d_reg <= cs_s_reg;
        mosi_m_reg <= mosi_in;
        mosi_s_reg <= mosi_m_reg;
    end
end

wire in_frame = ~cs_s_reg;
wire sclk_rise = in_frame & sclk_s_reg & ~sclk_d_reg;
wire sclk_fall = in_frame & ~sclk_s_reg & sclk_d_reg;
wire frame_start = cs_d_reg & ~cs_s_reg;
wire frame_end = ~cs_d_reg & cs_s_reg;

////////////////////////////////////////////////////////////////////////////////
// receive shifter and frame checks

reg [23:0] rx_reg;
reg [4:0] bit_cnt_reg;

// count saturates so an overlong frame cannot wrap back to 24

always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        rx_reg <= 24'h000000;
        bit_cnt_reg <= 5'h00;
    end else if (frame_start) begin
        bit_cnt_reg <= 5'h00;
    end else if (sclk_rise) begin
        rx_reg <= {rx_reg[22:0], mosi_s_reg};
        if (bit_cnt_reg != `DDR_CNT_MAX)
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
end

wire [1:0] rx_op = rx_reg[`DDR_OP_MSB:`DDR_ADDR_MSB+1]; // RULE17
wire [5:0] rx_addr = rx_reg[`DDR_ADDR_MSB:`DDR_ADDR_LSB];
wire [14:0] rx_data = rx_reg[`DDR_DATA_MSB:`DDR_DATA_LSB];
wire len_ok = (bit_cnt_reg == `DDR_FRAME_BITS); // RULE19
wire par_ok = ^rx_reg; // RULE18
wire is_write = (rx_op == `DDR_OP_WRITE);
wire good_frame = frame_end & len_ok & par_ok;
// status addresses lie above the write range, so they stay read only
// RULE7 RULE1 RULE4
wire do_write = good_frame & is_write & (rx_addr <= `DDR_CTRL_LAST);
wire do_read = good_frame & ~is_write;
wire ctrl_addr = (rx_addr <= `DDR_CTRL_LAST);
wire stat_addr = (rx_addr >= `DDR_ADDR_FAIL) & (rx_addr <= `DDR_ADDR_CF6);

////////////////////////////////////////////////////////////////////////////////
// control shadows and applied copies

reg [134:0] shadow_reg;

always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in)
        shadow_reg <= {`DDR_NUM_CTRL{`DDR_CTRL_RESET}}; // RULE9
    else if (do_write)
        shadow_reg[rx_addr[3:0]*`DDR_DATA_W +: `DDR_DATA_W] <= rx_data; // RULE4 RULE21
end

// deferred registers follow the shadow only between actuations, so a
// half-written setup never leaks into a running sequence
genvar g;
generate
    for (g = 0; g < `DDR_NUM_CTRL; g = g + 1) begin : g_apply
        always @(posedge sys_clk_in or negedge resetn_in) begin
            if (!resetn_in)
                ctrl_active_out[g*15 +: 15] <= `DDR_CTRL_RESET; // RULE9
            else if (g >= `DDR_IMMED_FIRST)
                ctrl_active_out[g*15 +: 15] <= shadow_reg[g*15 +: 15]; // RULE3
            else if (!actuation_busy_in)
                ctrl_active_out[g*15 +: 15] <= shadow_reg[g*15 +: 15]; // RULE2 RULE10
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// driver polarity and global pwm rate

wire [14:0] cr0 = ctrl_active_out[14:0];
wire [5:0] hs_en = cr0[`DDR_CR0_HS_LSB +: 6]; // RULE8
wire [5:0] ls_en = cr0[`DDR_CR0_LS_LSB +: 6];
wire [2:0] freq_sel = cr0[`DDR_CR0_FREQ_LSB +: 3];

always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        high_side_on_out <= 6'h00;
        low_side_on_out <= 6'h00;
    end else begin
        high_side_on_out <= hs_en & ~ls_en; // RULE11
        low_side_on_out <= ls_en & ~hs_en; // RULE11
    end
end

// periods fixed at elaboration, no divider in the fabric
wire [95:0] pwm_per_tab;
generate
    for (g = 0; g < 8; g = g + 1) begin : g_pwm
        localparam integer PER = `DDR_SYS_CLK_HZ / (`DDR_PWM_BASE_HZ + g * `DDR_PWM_STEP_HZ); // RULE12
        assign pwm_per_tab[g*12 +: 12] = PER[11:0];
    end
endgenerate

wire [11:0] pwm_per = pwm_per_tab[freq_sel*12 +: 12];
reg [11:0] pwm_cnt_reg;

// one counter for all six drivers keeps their pwm edges aligned
always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        pwm_cnt_reg <= 12'h000;
        pwm_tick_out <= 1'b0;
    end else if (pwm_cnt_reg >= pwm_per - 12'h001) begin
        pwm_cnt_reg <= 12'h000;
        pwm_tick_out <= 1'b1; // RULE13
    end else begin
        pwm_cnt_reg <= pwm_cnt_reg + 12'h001;
        pwm_tick_out <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// sticky link flags and global status byte

reg serial_fail_reg;
reg write_fail_flag_reg;
reg read_fail_reg;
reg reset_occurred_flag_reg;
// frame error flags describe the last frame only
reg frame_error_flag_1_reg;
reg frame_error_flag_2_reg;
wire clr_fail = do_read & (rx_addr == `DDR_ADDR_FAIL);

// a new failure in the clearing cycle wins over the clear
always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        serial_fail_reg <= 1'b0;
        write_fail_flag_reg <= 1'b0;
        read_fail_reg <= 1'b0;
        reset_occurred_flag_reg <= 1'b1;
        frame_error_flag_1_reg <= 1'b0;
        frame_error_flag_2_reg <= 1'b0;
    end else if (frame_end) begin
        serial_fail_reg <= ~len_ok | (serial_fail_reg & ~clr_fail); // RULE19
        write_fail_flag_reg <= (len_ok & ~par_ok & is_write) | (write_fail_flag_reg & ~clr_fail); // RULE21
        read_fail_reg <= (len_ok & ~par_ok & ~is_write) | (read_fail_reg & ~clr_fail);
        reset_occurred_flag_reg <= reset_occurred_flag_reg & ~clr_fail;
        frame_error_flag_1_reg <= len_ok & ~par_ok;
        frame_error_flag_2_reg <= good_frame & ~ctrl_addr & ~stat_addr;
    end
end

wire device_error = logic_supply_undervoltage_in | pump_low_flag_in | battery_low_inhibit_flag_in |
    battery_overvoltage_flag_in | aux_rail_undervoltage_in | (|thermal_shutdown_flag_in) |
    (|output_fault_code_in) | (|drain_source_flag_in) | (|external_fault_code_in);
wire global_warning = |thermal_warning_flag_in;
wire link_error = serial_fail_reg | frame_error_flag_1_reg | frame_error_flag_2_reg;
wire global_status_flag_n = ~(device_error | global_warning | link_error | reset_occurred_flag_reg);
// RULE15
wire [7:0] global_byte = {global_status_flag_n, reset_occurred_flag_reg, serial_fail_reg,
    frame_error_flag_2_reg, frame_error_flag_1_reg, device_error, global_warning, 1'b0};

////////////////////////////////////////////////////////////////////////////////
// readback select, captured at end of the request frame

reg [14:0] rd_sel;

always @* begin
    rd_sel = 15'h0000;
    if (ctrl_addr)
        rd_sel = shadow_reg[rx_addr[3:0]*`DDR_DATA_W +: `DDR_DATA_W]; // RULE10
    else begin
        case (rx_addr) // RULE14 RULE16 RULE20
            `DDR_ADDR_FAIL: rd_sel = {serial_fail_reg, write_fail_flag_reg, read_fail_reg,
                output_fault_code_in};
            `DDR_ADDR_SUPPLY: rd_sel = {logic_supply_undervoltage_in, state_bit_high_in,
                state_bit_low_in, drain_source_flag_in, external_fault_code_in};
            `DDR_ADDR_THERM: rd_sel = {pump_low_flag_in, battery_low_inhibit_flag_in,
                battery_overvoltage_flag_in, thermal_shutdown_flag_in, thermal_warning_flag_in};
            `DDR_ADDR_CF1: rd_sel = {aux_rail_undervoltage_in, 4'h0, current_feedback_value_in[9:0]};
            `DDR_ADDR_CF2: rd_sel = {5'h00, current_feedback_value_in[19:10]};
            `DDR_ADDR_CF3: rd_sel = {5'h00, current_feedback_value_in[29:20]};
            `DDR_ADDR_CF4: rd_sel = {5'h00, current_feedback_value_in[39:30]};
            `DDR_ADDR_CF5: rd_sel = {5'h00, current_feedback_value_in[49:40]};
            `DDR_ADDR_CF6: rd_sel = {5'h00, current_feedback_value_in[59:50]};
            default: rd_sel = 15'h0000;
        endcase
    end
end

reg [14:0] rd_data_reg;

// answer to a read comes out in the next frame, as the bits are
// already leaving before this frame's address is known
always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in)
        rd_data_reg <= 15'h0000;
    else if (do_read)
        rd_data_reg <= rd_sel;
end

////////////////////////////////////////////////////////////////////////////////
// transmit shifter

// parity over the body makes the whole response odd
wire [22:0] tx_body = {global_byte, rd_data_reg};
reg [23:0] tx_reg;

always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        tx_reg <= 24'h000000;
        miso_out <= 1'b0;
    end else if (frame_start) begin
        tx_reg <= {tx_body, ~^tx_body}; // RULE18 RULE20
        miso_out <= tx_body[22];
    end else if (sclk_fall) begin
        tx_reg <= {tx_reg[22:0], 1'b0};
        miso_out <= tx_reg[22];
    end
end

// released outside frames so another device may share the line
assign miso_oe_out = in_frame;

endmodule // ddr_regs
`default_nettype wire

//--- ddr_regs_asserts.sv
// port assertions for the serial register bank
`timescale 1ns/10ps
`default_nettype none
module ddr_regs_asserts (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic chip_select_n_in,
    input wire logic miso_oe_out,
    input wire logic actuation_busy_in,
    input wire logic [134:0] ctrl_active_out,
    input wire logic [5:0] high_side_on_out,
    input wire logic [5:0] low_side_on_out,
    input wire logic pwm_tick_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    wire logic [2:0] fsel = ctrl_active_out[14:12];
    logic [2:0] fsel_reg;
    logic [11:0] gap_reg;
    logic seen_reg;
    logic chg_reg;
    // a rate change mid-period leaves that period unchecked
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fsel_reg <= 3'h0;
            gap_reg <= 12'h000;
            seen_reg <= 1'b0;
            chg_reg <= 1'b0;
        end else begin
            fsel_reg <= fsel;
            gap_reg <= pwm_tick_out ? 12'h000 : gap_reg + 12'h001;
            seen_reg <= seen_reg | pwm_tick_out;
            chg_reg <= (fsel != fsel_reg) ? 1'b1 : (pwm_tick_out ? 1'b0 : chg_reg);
        end
    end
    function automatic logic [11:0] per_m1(input logic [2:0] c);
        per_m1 = 12'(25000000 / (10240 + 2048 * c) - 1);
    endfunction
    sequence s_cs_idle; chip_select_n_in [*5]; endsequence
    sequence s_cs_sel; !chip_select_n_in [*8]; endsequence
    property p_oe_off; s_cs_idle |-> !miso_oe_out; endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso driven while deselected");
    property p_oe_on; s_cs_sel |-> miso_oe_out; endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso not driven in frame");
    property p_no_shoot; (high_side_on_out & low_side_on_out) == 6'h00; endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("both sides on");
    property p_hs_dec; $stable(ctrl_active_out[11:0]) [*3] |-> high_side_on_out == (ctrl_active_out[11:6] & ~ctrl_active_out[5:0]); endproperty
    a_hs_dec: assert property (p_hs_dec) else $error("high side decode");
    property p_ls_dec; $stable(ctrl_active_out[11:0]) [*3] |-> low_side_on_out == (ctrl_active_out[5:0] & ~ctrl_active_out[11:6]); endproperty
    a_ls_dec: assert property (p_ls_dec) else $error("low side decode");
    property p_defer; actuation_busy_in [*2] |-> $stable(ctrl_active_out[89:0]); endproperty
    a_defer: assert property (p_defer) else $error("held register applied in actuation");
    property p_immed; s_cs_sel |-> $stable(ctrl_active_out[134:90]); endproperty
    a_immed: assert property (p_immed) else $error("immediate register moved in frame");
    property p_tick; pwm_tick_out |=> !pwm_tick_out; endproperty
    a_tick: assert property (p_tick) else $error("pwm tick too long");
    property p_period; pwm_tick_out && seen_reg && !chg_reg && fsel == fsel_reg |-> gap_reg == per_m1(fsel); endproperty
    a_period: assert property (p_period) else $error("pwm period wrong");
endmodule // ddr_regs_asserts
bind ddr_regs ddr_regs_asserts i_chk (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .chip_select_n_in(chip_select_n_in), .miso_oe_out(miso_oe_out), .actuation_busy_in(actuation_busy_in),
    .ctrl_active_out(ctrl_active_out), .high_side_on_out(high_side_on_out), .low_side_on_out(low_side_on_out),
    .pwm_tick_out(pwm_tick_out));
`default_nettype wire

//--- ddr_host.sv
// host controller model: serial link master
`timescale 1ns/10ps
`default_nettype none
module ddr_host (
    input wire logic clk_in,
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // top n bits of tx go out; sclk stands low outside frames
    task automatic frame(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx = 24'h000000;
        @(negedge clk_in) cs_n_out = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            mosi_out = tx[i];
            repeat (4) @(negedge clk_in);
            sclk_out = 1'b1;
            rx[i] = miso_in;
            repeat (4) @(negedge clk_in);
            sclk_out = 1'b0;
        end
        repeat (4) @(negedge clk_in);
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
        repeat (8) @(negedge clk_in);
    endtask
endmodule // ddr_host
`default_nettype wire

//--- ddr_regs_bench.sv
// self-checking bench for the serial register bank
`timescale 1ns/10ps
`default_nettype none
module ddr_regs_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic busy = 1'b0;
    logic [42:0] st = 43'h5a3c96a5b1e;
    logic [59:0] cf = 60'h3a51c22b70f1552;
    logic [23:0] rx;
    wire logic sclk, cs_n, mosi, miso, oe, tick;
    wire logic [134:0] ctrl;
    wire logic [5:0] hs, ls;
    int fails = 0;
    int comparisons = 0;
    localparam logic [14:0] D0 = 15'h50c5;
    localparam logic [14:0] D1 = 15'h20c5;
    ddr_regs i_dut (.sys_clk_in(clk), .resetn_in(rst_n), .sclk_in(sclk), .chip_select_n_in(cs_n),
        .mosi_in(mosi), .miso_out(miso), .miso_oe_out(oe), .actuation_busy_in(busy),
        .output_fault_code_in(st[11:0]), .logic_supply_undervoltage_in(st[12]), .state_bit_high_in(st[13]),
        .state_bit_low_in(st[14]), .drain_source_flag_in(st[22:15]), .external_fault_code_in(st[26:23]),
        .pump_low_flag_in(st[27]), .battery_low_inhibit_flag_in(st[28]), .battery_overvoltage_flag_in(st[29]),
        .thermal_shutdown_flag_in(st[35:30]), .thermal_warning_flag_in(st[41:36]),
        .aux_rail_undervoltage_in(st[42]), .current_feedback_value_in(cf), .ctrl_active_out(ctrl),
        .high_side_on_out(hs), .low_side_on_out(ls), .pwm_tick_out(tick));
    ddr_host i_host (.clk_in(clk), .miso_in(oe ? miso : 1'b1), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [134:0] got, input logic [134:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [23:0] cmd(input logic [1:0] op, input logic [5:0] a, input logic [14:0] d);
        cmd = {op, a, d, ~^{op, a, d}};
    endfunction
    task automatic wr(input logic [5:0] a, input logic [14:0] d);
        i_host.frame(cmd(2'b00, a, d), 24, rx);
    endtask
    // read data comes back in the following frame
    task automatic rd(input logic [5:0] a, input logic [14:0] exp);
        i_host.frame(cmd(2'b01, a, 15'h0000), 24, rx);
        i_host.frame(cmd(2'b01, 6'h00, 15'h0000), 24, rx);
        check(rx[15:1], exp);
        check(^rx, 1'b1);
    endtask
    task automatic t_reset;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check(ctrl, 135'h0);
        check({hs, ls}, 12'h000);
        i_host.frame(cmd(2'b01, 6'h00, 15'h0000), 24, rx);
        check({rx[23:22], rx[16]}, 3'b010);
    endtask
    task automatic t_polarity;
        wr(6'h00, D0);
        check(ctrl[14:0], D0);
        check({hs, ls}, {6'b000010, 6'b000100});
        wr(6'h01, 15'h0014);
        check(ctrl[29:15], 15'h0014);
        rd(6'h00, D0);
    endtask
    // the 00H write during actuation differs from D0 only in the rate bits; polarity stays put
    task automatic t_defer;
        busy = 1'b1;
        wr(6'h00, D1);
        check(ctrl[14:0], D0);
        wr(6'h07, 15'h2a5a);
        check(ctrl[119:105], 15'h2a5a);
        busy = 1'b0;
        repeat (4) @(negedge clk);
        check(ctrl[14:0], D1);
    endtask
    task automatic t_status;
        wr(6'h12, 15'h7fff);
        rd(6'h02, 15'h0000);
        rd(6'h12, {st[27], st[28], st[29], st[35:30], st[41:36]});
        rd(6'h13, {st[42], 4'h0, cf[9:0]});
        rd(6'h18, {5'h00, cf[59:50]});
    endtask
    task automatic t_faults;
        i_host.frame(cmd(2'b00, 6'h00, 15'h7fff) ^ 24'h000001, 24, rx);
        check(ctrl[14:0], D1);
        i_host.frame(cmd(2'b00, 6'h00, 15'h7fff), 22, rx);
        check(rx[19], 1'b1);
        check(ctrl[14:0], D1);
        i_host.frame(cmd(2'b11, 6'h3f, 15'h0000), 24, rx);
        check(rx[21], 1'b1);
        i_host.frame(cmd(2'b01, 6'h10, 15'h0000), 24, rx);
        check({rx[20], rx[15:1]}, 16'h8000);
        i_host.frame(cmd(2'b01, 6'h00, 15'h0000), 24, rx);
        check(rx[15:1], {3'b110, st[11:0]});
        check(rx[22:21], 2'b00);
        check(^rx, 1'b1);
    endtask
    // first interval may straddle the rate change, the second is judged
    task automatic t_pwm;
        int n;
        for (int c = 0; c < 8; c++) begin
            wr(6'h00, {c[2:0], D1[11:0]});
            for (int k = 0; k < 2; k++) begin
                repeat (3000) if (tick !== 1'b1) @(negedge clk);
                n = 0;
                do begin @(negedge clk); n++; end while (tick !== 1'b1 && n < 3000);
            end
            check(n, 25000000 / (10240 + 2048 * c));
        end
    endtask
    task final_report;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        t_reset;
        t_polarity;
        t_defer;
        t_status;
        t_faults;
        t_pwm;
        t_reset;
        final_report;
    end
    initial begin
        #3000000;
        fails++;
        final_report;
    end
endmodule // ddr_regs_bench
`default_nettype wire
